//--- logic/flash_prog_defines.svh
/*
  Offsets, bit positions, command patterns, reset values and timing counts
  of the self-programming controller.
  Assumes it is included by bare name from the package and the modules.
*/
// Summary of operation
// - Boot fuse picks application or boot vector
// - Fuses are never writable from the core
// - Ready interrupt requested while enable bit clear
// - Section-bound erase or write sets busy flag
// - Busy cleared by re-enable or buffer load
// - Re-enable ignored while erase or write runs
// - Re-enable write discards the loaded buffer
// - Lock set programs lock bits from R0
// - Armed load-program returns lock or fuse bits
// - Page write copies buffer into pointer page
// - Core stalled for operations on non-section pages
// - Page erase clears the pointer page
// - Plain enable loads R1:R0 into buffer
// - Enable clears on completion or window timeout
// - Only five command patterns have effect
// - Control bit five reads as zero
// - Target page latched when operation starts
// - Pointer splits into page and word fields
// - Load-program uses pointer bit zero
// - Buffer words load in any order
// - Buffer cleared after write, re-enable, reset
`ifndef FLASH_PROG_DEFINES_SVH
`define FLASH_PROG_DEFINES_SVH

// Register indices; byte address is four times the index
`define CSR_INDEX 8'h37
`define ADDR_INDEX 8'h38
`define DATA_INDEX 8'h39
`define CMD_INDEX 8'h3a
`define RESULT_INDEX 8'h3b
`define STATUS_INDEX 8'h3c

// Control/status bit positions
`define BIT_IRQ_EN 7
`define BIT_BUSY 6
`define BIT_REEN 4
`define BIT_LOCK 3
`define BIT_PWRT 2
`define BIT_PERS 1
`define BIT_EN 0

// Command register bit positions
`define CMD_STORE_BIT 0
`define CMD_LOAD_BIT 1

// Legal lower-five-bit command patterns
`define CMD_REEN 5'h11
`define CMD_LOCK 5'h09
`define CMD_PWRT 5'h05
`define CMD_PERS 5'h03
`define CMD_LOAD 5'h01

// Reset values
`define CSR_RESET 8'h00
`define LOCK_RESET 8'hff
`define APP_RESET_VECTOR 16'h0000

// Arming windows in clocks
`define STORE_WINDOW 3'h4
`define LOAD_WINDOW 2'h3

// Programming time
`define PROG_TIME_US 4000
`define CLK_PERIOD_NS 25
`define PROG_CYCLES (`PROG_TIME_US * 1000 / `CLK_PERIOD_NS)

`endif

//--- logic/flash_prog_pkg.sv
/*
  Types shared by the self-programming controller and its test bench.
  Assumes the defines header sits beside it.
*/
`default_nettype none
`include "flash_prog_defines.svh"

package flash_prog_pkg;

  // Bus transfer type
  typedef logic [1:0] htrans_t;

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    st_idle = 3'h1,
    st_armed = 3'h2,
    st_busy = 3'h4
  } seq_state_t;

endpackage

`default_nettype wire

//--- logic/page_buffer_if.sv
/*
  Link between the sequencer and the temporary page buffer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface page_buffer_if #(
  parameter int WORD_BITS = 16,
  parameter int INDEX_BITS = 6
);
  logic load; // One-cycle word load request
  logic clear; // One-cycle whole-buffer clear
  logic [INDEX_BITS-1:0] load_index; // Word slot to fill
  logic [WORD_BITS-1:0] load_data; // Word to store
  logic [INDEX_BITS-1:0] read_index; // Slot the array reads
  logic [WORD_BITS-1:0] read_data; // Registered read word

  modport ctrl (output load, clear, load_index, load_data, read_index, input read_data);
  modport store (input load, clear, load_index, load_data, read_index, output read_data);
endinterface

`default_nettype wire

//--- logic/page_buffer.sv
/*
  Temporary page buffer: one word per slot, each slot writable once
  between clears.
  Assumes clear and load are one-cycle pulses from the sequencer.
*/
`timescale 1ns/1ps
`default_nettype none

module page_buffer #(
  parameter int WORD_BITS = 16,
  parameter int INDEX_BITS = 6
) (
  input wire logic hclk,
  input wire logic hresetn,
  page_buffer_if.store port
);
  localparam int DEPTH = 1 << INDEX_BITS;

  // All buffer state
  typedef struct packed {
    logic [DEPTH-1:0][WORD_BITS-1:0] words; // Stored words
    logic [DEPTH-1:0] filled; // Slot already written
    logic [WORD_BITS-1:0] rd; // Read register
  } buf_state_t;

  buf_state_t cur;
  buf_state_t next_state;

  // Clear wins over a load in the same cycle
  always_comb begin
    next_state = cur;
    next_state.rd = cur.words[port.read_index];
    if (port.clear) begin
      next_state.words = '0;
      next_state.filled = '0;
    end else if (port.load && !cur.filled[port.load_index]) begin
      // Direct indexing, so any load order works
      next_state.words[port.load_index] = port.load_data;
      next_state.filled[port.load_index] = 1'b1;
    end
  end

  // State register; reset empties the buffer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur <= '0;
    end else begin
      cur <= next_state;
    end
  end

  assign port.read_data = cur.rd;

  a_slot_write_once: assert property (@(posedge hclk) disable iff (!hresetn)
    (port.load && !port.clear && cur.filled[port.load_index]) |=> $stable(cur.words))
    else $error("filled slot was overwritten");

  a_clear_empties: assert property (@(posedge hclk) disable iff (!hresetn)
    port.clear |=> (cur.filled == '0))
    else $error("clear left a slot filled");

endmodule // page_buffer

`default_nettype wire

//--- logic/flash_self_program_control.sv
/*
  Self-programming sequencer for the program flash, reached over an
  AHB-Lite slave port: control/status, address pointer, data word,
  command strobes, load result and a status word.
  Assumes a single AHB-Lite master, word transfers only, and a flash
  array that times itself from the start pulses and reads the buffer.
*/
`timescale 1ns/1ps
`default_nettype none

`include "flash_prog_defines.svh"

module flash_self_program_control #(
  parameter int PAGE_LOG2 = 6, // Words per page, log2
  parameter int HALT_FIRST_PAGE = 224, // First page outside the section
  parameter logic [15:0] BOOT_START_ADDR = 16'h7000, // Boot loader vector
  parameter int PROG_CYCLES = `PROG_CYCLES // Erase or write duration
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire flash_prog_pkg::htrans_t htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic global_irq_enable,
  input wire logic boot_reset_select_fuse,
  input wire logic [7:0] fuse_low,
  input wire logic [7:0] fuse_high,
  input wire logic [7:0] fuse_ext,
  input wire logic [PAGE_LOG2-1:0] buf_read_index,
  output logic [15:0] buf_read_data,
  output logic [15:0] reset_vector,
  output logic ready_irq,
  output logic section_busy_flag,
  output logic cpu_halt,
  output logic flash_erase_start,
  output logic flash_write_start,
  output logic [14-PAGE_LOG2:0] flash_page,
  output logic [7:0] lock_bits
);
  import flash_prog_pkg::*;

  localparam int PAGE_BITS = 15 - PAGE_LOG2;

  // Refuse geometries the pointer split cannot serve
  if (PAGE_LOG2 < 1 || PAGE_LOG2 > 7) begin : g_bad_page
    $error("PAGE_LOG2 must lie in 1..7");
  end
  if (PROG_CYCLES < 2) begin : g_bad_time
    $error("PROG_CYCLES must be at least 2");
  end

  // All state of the sequencer
  typedef struct packed {
    logic [24:0] sync1; // Fuse pins, first stage
    logic [24:0] sync2; // Fuse pins, second stage
    logic [1:0] settle; // Counts edges until fuses are stable
    logic [15:0] vector; // Captured reset vector
    logic irq_en; // Ready interrupt enable
    logic busy; // Section busy flag
    logic reen; // Read re-enable bit
    logic lock; // Lock bit set
    logic pwrt; // Page write bit
    logic pers; // Page erase bit
    logic en; // Store program enable
    seq_state_t fsm; // Sequencer state
    logic [2:0] store_win; // Clocks left for a store
    logic [1:0] load_win; // Clocks left for a load
    logic [31:0] op_count; // Clocks left in erase or write
    logic [15:0] addr_ptr; // Address pointer
    logic [15:0] data_word; // R1:R0
    logic [7:0] result; // Load-program destination
    logic [7:0] lock_bits; // Lock bits, 0 means programmed
    logic [PAGE_BITS-1:0] page; // Latched target page
    logic halt_op; // Running op targets non-section page
    logic erase_start; // Erase pulse to the array
    logic write_start; // Write pulse to the array
    logic cpu_halt; // Core stall
    logic ready_irq; // Interrupt request
    logic wr_pending; // Write data phase due
    logic [7:0] wr_index; // Register index of that write
    logic [31:0] rd_data; // Read data phase value
    logic bus_ready; // Slave ready
    logic buf_load; // Buffer load pulse
    logic buf_clear; // Buffer clear pulse
    logic [PAGE_LOG2-1:0] buf_index; // Buffer slot
    logic [15:0] buf_data; // Buffer word
  } state_t;

  state_t cur;
  state_t next_state;

  // Address phase of a real transfer
  logic bus_accept;
  assign bus_accept = hsel && hready && htrans[1];

  page_buffer_if #(.WORD_BITS(16), .INDEX_BITS(PAGE_LOG2)) pbuf ();

  // Next-state logic, one pass in priority order
  always_comb begin
    logic [4:0] low5;
    logic store_cmd;
    logic load_cmd;
    logic [7:0] rd_index;
    logic [31:0] rd_value;
    low5 = hwdata[4:0];
    store_cmd = 1'b0;
    load_cmd = 1'b0;
    rd_index = haddr[9:2];
    rd_value = 32'h0;
    next_state = cur;

    // Fuse pins are only sampled; no path ever writes them
    next_state.sync1 = {boot_reset_select_fuse, fuse_ext, fuse_high, fuse_low};
    next_state.sync2 = cur.sync1;

    // Pulses last one cycle
    next_state.erase_start = 1'b0;
    next_state.write_start = 1'b0;
    next_state.buf_load = 1'b0;
    next_state.buf_clear = 1'b0;
    next_state.bus_ready = 1'b1;

    // Catch the vector once the synchroniser has filled after release
    if (cur.settle != 2'h3) begin
      next_state.settle = cur.settle + 2'h1;
      if (cur.settle == 2'h2) begin
        // Unprogrammed (1) starts the application
        next_state.vector = cur.sync2[24] ? `APP_RESET_VECTOR : BOOT_START_ADDR;
      end
    end

    // Load window runs down on its own
    if (cur.load_win != 2'h0) begin
      next_state.load_win = cur.load_win - 2'h1;
    end

    // Store window timeout clears the whole command
    if (cur.fsm == st_armed) begin
      next_state.store_win = cur.store_win - 3'h1;
      if (cur.store_win == 3'h1) begin
        next_state.fsm = st_idle;
        next_state.en = 1'b0;
        next_state.reen = 1'b0;
        next_state.lock = 1'b0;
        next_state.pwrt = 1'b0;
        next_state.pers = 1'b0;
      end
    end

    // Erase or write in flight; enable stays high till the end
    if (cur.fsm == st_busy) begin
      next_state.op_count = cur.op_count - 32'h1;
      if (cur.op_count == 32'h1) begin
        next_state.fsm = st_idle;
        next_state.en = 1'b0;
        next_state.pwrt = 1'b0;
        next_state.pers = 1'b0;
        next_state.cpu_halt = 1'b0;
        next_state.buf_clear = cur.pwrt;
      end
    end

    // Address phase: decode and prepare read data
    next_state.wr_pending = bus_accept && hwrite;
    if (bus_accept) begin
      next_state.wr_index = rd_index;
      case (rd_index)
        `CSR_INDEX: begin
          // Bit five is hard zero
          rd_value = {24'h0, cur.irq_en, cur.busy, 1'b0, cur.reen, cur.lock, cur.pwrt, cur.pers, cur.en};
        end
        `ADDR_INDEX: begin
          rd_value = {16'h0, cur.addr_ptr};
        end
        `DATA_INDEX: begin
          rd_value = {16'h0, cur.data_word};
        end
        `RESULT_INDEX: begin
          rd_value = {24'h0, cur.result};
        end
        `STATUS_INDEX: begin
          rd_value = {8'h0, cur.lock_bits, cur.vector};
        end
        default: begin
          rd_value = 32'h0;
        end
      endcase
      next_state.rd_data = hwrite ? 32'h0 : rd_value;
    end

    // Data phase of a write
    if (cur.wr_pending) begin
      case (cur.wr_index)
        `CSR_INDEX: begin
          next_state.irq_en = hwdata[`BIT_IRQ_EN];
          // Nothing re-arms while erase or write is running
          if (cur.fsm != st_busy) begin
            case (low5)
              `CMD_REEN, `CMD_LOCK, `CMD_PWRT, `CMD_PERS, `CMD_LOAD: begin
                next_state.reen = low5[`BIT_REEN];
                next_state.lock = low5[`BIT_LOCK];
                next_state.pwrt = low5[`BIT_PWRT];
                next_state.pers = low5[`BIT_PERS];
                next_state.en = 1'b1;
                next_state.fsm = st_armed;
                next_state.store_win = `STORE_WINDOW;
                next_state.load_win = low5[`BIT_LOCK] ? `LOAD_WINDOW : 2'h0;
                // Partially loaded data is thrown away
                next_state.buf_clear = low5[`BIT_REEN];
              end
              default: begin
                // Any other pattern changes nothing
                next_state.fsm = next_state.fsm;
              end
            endcase
          end
        end
        `ADDR_INDEX: begin
          next_state.addr_ptr = hwdata[15:0];
        end
        `DATA_INDEX: begin
          next_state.data_word = hwdata[15:0];
        end
        `CMD_INDEX: begin
          store_cmd = hwdata[`CMD_STORE_BIT];
          load_cmd = hwdata[`CMD_LOAD_BIT];
        end
        default: begin
          store_cmd = 1'b0;
        end
      endcase
    end

    // Store-program instruction; ignored unless armed
    if (store_cmd && cur.fsm == st_armed) begin
      next_state.fsm = st_idle;
      next_state.en = 1'b0;
      next_state.reen = 1'b0;
      next_state.lock = 1'b0;
      next_state.pwrt = 1'b0;
      next_state.pers = 1'b0;
      next_state.load_win = 2'h0;
      if (cur.pwrt || cur.pers) begin
        // Upper pointer bits pick the page; latched here
        next_state.page = cur.addr_ptr[15:PAGE_LOG2+1];
        next_state.halt_op = 32'(cur.addr_ptr[15:PAGE_LOG2+1]) >= HALT_FIRST_PAGE;
        if (32'(cur.addr_ptr[15:PAGE_LOG2+1]) < HALT_FIRST_PAGE) begin
          next_state.busy = 1'b1;
        end
        // Stall covers the whole operation
        next_state.cpu_halt = 32'(cur.addr_ptr[15:PAGE_LOG2+1]) >= HALT_FIRST_PAGE;
        next_state.erase_start = cur.pers;
        next_state.write_start = cur.pwrt;
        next_state.fsm = st_busy;
        next_state.en = 1'b1;
        next_state.pwrt = cur.pwrt;
        next_state.pers = cur.pers;
        next_state.op_count = 32'(PROG_CYCLES);
      end else if (cur.lock) begin
        // Zero bits in R0 bits 5..0 program, bits 7..6 stay one; programmed bits never return
        next_state.lock_bits = cur.lock_bits & {2'h3, cur.data_word[5:0]};
      end else if (cur.reen) begin
        next_state.busy = 1'b0;
      end else begin
        // Word slot from pointer, bit zero ignored
        next_state.buf_load = 1'b1;
        next_state.buf_index = cur.addr_ptr[PAGE_LOG2:1];
        next_state.buf_data = cur.data_word;
        next_state.busy = 1'b0;
      end
    end else if (load_cmd && cur.fsm == st_armed && cur.lock && cur.load_win != 2'h0) begin
      // Byte-wise pointer, so bit zero counts here
      case (cur.addr_ptr[1:0])
        2'h0: begin
          next_state.result = cur.sync2[7:0];
        end
        2'h1: begin
          next_state.result = cur.lock_bits;
        end
        2'h2: begin
          next_state.result = cur.sync2[23:16];
        end
        default: begin
          next_state.result = cur.sync2[15:8];
        end
      endcase
      next_state.fsm = st_idle;
      next_state.en = 1'b0;
      next_state.lock = 1'b0;
      next_state.load_win = 2'h0;
    end

    // Level request while enable is clear
    next_state.ready_irq = next_state.irq_en && global_irq_enable && !next_state.en;
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur <= '0;
      cur.fsm <= st_idle;
      cur.lock_bits <= `LOCK_RESET;
      cur.bus_ready <= 1'b1;
    end else begin
      cur <= next_state;
    end
  end

  // Buffer link
  assign pbuf.load = cur.buf_load;
  assign pbuf.clear = cur.buf_clear;
  assign pbuf.load_index = cur.buf_index;
  assign pbuf.load_data = cur.buf_data;
  assign pbuf.read_index = buf_read_index;

  page_buffer #(.WORD_BITS(16), .INDEX_BITS(PAGE_LOG2)) u_buffer (
    .hclk(hclk),
    .hresetn(hresetn),
    .port(pbuf.store)
  );

  // Outputs, all from flip-flops; response is always OKAY
  assign hreadyout = cur.bus_ready;
  assign hresp = 1'b0;
  assign hrdata = cur.rd_data;
  assign buf_read_data = pbuf.read_data;
  assign reset_vector = cur.vector;
  assign ready_irq = cur.ready_irq;
  assign section_busy_flag = cur.busy;
  assign cpu_halt = cur.cpu_halt;
  assign flash_erase_start = cur.erase_start;
  assign flash_write_start = cur.write_start;
  assign flash_page = cur.page;
  assign lock_bits = cur.lock_bits;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Request is registered from the next state, so it matches the current bits and last cycle's global enable
  a_irq_when_idle: assert property (ready_irq == (cur.irq_en && $past(global_irq_enable) && !cur.en))
    else $error("ready interrupt missing");

  a_busy_on_start: assert property ((cur.erase_start || cur.write_start) && !cur.halt_op |-> cur.busy)
    else $error("busy flag not set");

  a_stall_whole_op: assert property ((cur.fsm == st_busy) && cur.halt_op |-> cpu_halt)
    else $error("core not stalled");

  a_enable_held_busy: assert property ((cur.fsm == st_busy) |-> cur.en)
    else $error("enable dropped during operation");

  a_window_bounded: assert property ($rose(cur.fsm == st_armed) |-> ##[1:5] (cur.fsm != st_armed))
    else $error("arming window overran");

  a_reserved_zero: assert property (bus_accept && !hwrite && haddr[9:2] == `CSR_INDEX |=> !hrdata[5])
    else $error("reserved bit read as one");

  a_bad_pattern: assert property (cur.wr_pending && cur.wr_index == `CSR_INDEX && cur.fsm == st_idle
    && !(hwdata[4:0] inside {`CMD_REEN, `CMD_LOCK, `CMD_PWRT, `CMD_PERS, `CMD_LOAD})
    |=> cur.fsm == st_idle)
    else $error("illegal pattern armed the sequencer");

  a_lock_one_way: assert property (##1 ((cur.lock_bits & ~$past(cur.lock_bits)) == 8'h0))
    else $error("lock bit returned to one");

  a_write_clears: assert property ((cur.fsm == st_busy) && cur.pwrt && cur.op_count == 32'h1
    |=> cur.buf_clear)
    else $error("buffer kept after page write");

  a_unarmed_store: assert property (cur.wr_pending && cur.wr_index == `CMD_INDEX && cur.fsm == st_idle
    |=> !cur.erase_start && !cur.write_start && !cur.buf_load)
    else $error("unarmed store had effect");

endmodule // flash_self_program_control

`default_nettype wire

//--- tb/boot_core.sv
/*
  Bus master standing in for the core that runs boot loader code.
  Assumes one AHB-Lite slave whose hreadyout comes back as hready.
*/
`timescale 1ns/1ps
`default_nettype none
`include "flash_prog_defines.svh"
module boot_core (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output flash_prog_pkg::htrans_t htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  import flash_prog_pkg::*;
  int hung = 0; // Bus waits that ran out; the bench ends the run on it
  // Bus idle until the first transfer
  initial begin
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
  end
  // Hold the current phase until an edge samples hready high
  task automatic await_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1 && n < 64) begin
      n++;
      @(posedge hclk);
    end
    if (n >= 64) begin
      hung++;
    end
  endtask
  // One single word transfer, entered just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rdv);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    await_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    await_ready();
    rdv = hrdata;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, idx, d, x);
  endtask
  task automatic rd(input logic [7:0] idx, output logic [31:0] d);
    xfer(1'b0, idx, 32'h0, d);
  endtask
  // Arm, then strobe two edges later: inside both the store and load windows
  task automatic cmd(input logic [7:0] csr, input logic [1:0] strobe);
    wr(`CSR_INDEX, {24'h0, csr});
    wr(`CMD_INDEX, {30'h0, strobe});
  endtask
endmodule // boot_core
`default_nettype wire

//--- tb/flash_self_program_control_tb.sv
/*
  Self-checking bench for the flash self-programming sequencer.
  Assumes the core model boot_core and a shortened programming time.
*/
`timescale 1ns/1ps
`default_nettype none
`include "flash_prog_defines.svh"
module flash_self_program_control_tb;
  import flash_prog_pkg::*;
  localparam int PROG = 20; // Short erase/write keeps the run brief
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, gie, fuse, ready_irq, busy, halt, erase_go, write_go;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [2:0] hsize;
  logic [7:0] f_low, f_high, f_ext, lock_bits;
  logic [5:0] buf_index;
  logic [15:0] buf_data, reset_vector;
  logic [8:0] page;
  htrans_t htrans;
  int mismatches = 0, n_compared = 0, starts = 0;
  boot_core boot_core_i (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  flash_self_program_control #(.PROG_CYCLES(PROG)) flash_self_program_control_i (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .global_irq_enable(gie), .boot_reset_select_fuse(fuse), .fuse_low(f_low), .fuse_high(f_high),
    .fuse_ext(f_ext), .buf_read_index(buf_index), .buf_read_data(buf_data), .reset_vector(reset_vector),
    .ready_irq(ready_irq), .section_busy_flag(busy), .cpu_halt(halt), .flash_erase_start(erase_go),
    .flash_write_start(write_go), .flash_page(page), .lock_bits(lock_bits));
  // 40 MHz clock
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // Count start pulses so a refused command can be seen to start nothing
  always @(posedge hclk) begin
    if (erase_go === 1'b1 || write_go === 1'b1) begin
      starts++;
    end
    if (boot_core_i.hung != 0) begin
      mismatches++;
      conclude();
    end
  end
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // A wait that ran out ends the run at once
  task automatic bound(input logic ok);
    if (ok !== 1'b1) begin
      mismatches++;
      $display("[FAIL] %0t wait ran out", $time);
      conclude();
    end
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    boot_core_i.rd(idx, r);
    chk(r, exp);
  endtask
  task automatic do_reset(input logic f, input logic [15:0] vec);
    fuse <= f;
    hresetn <= 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    chk(reset_vector, vec);
  endtask
  task automatic load_word(input logic [15:0] ptr, input logic [15:0] d);
    boot_core_i.wr(`ADDR_INDEX, {16'h0, ptr});
    boot_core_i.wr(`DATA_INDEX, {16'h0, d});
    boot_core_i.cmd(8'h01, 2'h1);
  endtask
  // Buffer read data lags its index by one cycle
  task automatic chk_buf(input logic [5:0] slot, input logic [15:0] exp);
    buf_index <= slot;
    repeat (3) @(posedge hclk);
    chk(buf_data, exp);
  endtask
  task automatic see_start(input logic wop);
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while ((wop ? write_go : erase_go) !== 1'b1 && n < 8);
    bound(wop ? write_go : erase_go);
  endtask
  // Poll the enable bit: it drops when the erase or write ends
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      boot_core_i.rd(`CSR_INDEX, r);
      n++;
    end while (r[0] !== 1'b0 && n < 40);
    bound(~r[0]);
  endtask
  task automatic t_reset();
    do_reset(1'b0, 16'h7000);
    do_reset(1'b1, 16'h0000);
    rdc(`CSR_INDEX, 32'h0);
    boot_core_i.wr(`STATUS_INDEX, 32'hffff_ffff);
    rdc(`STATUS_INDEX, 32'h00ff_0000);
    boot_core_i.wr(8'h3f, 32'hffff_ffff);
    rdc(8'h3f, 32'h0);
    chk(hresp, 32'h0);
    $display("test reset finished");
  endtask
  task automatic t_load();
    load_word(16'h000b, 16'hbeef); // slot 5, low pointer bit ignored
    load_word(16'h0004, 16'h1234);
    load_word(16'h000a, 16'h0bad);
    rdc(`CSR_INDEX, 32'h0);
    chk_buf(6'd5, 16'hbeef);
    chk_buf(6'd2, 16'h1234);
    $display("test load finished");
  endtask
  task automatic t_section();
    boot_core_i.wr(`ADDR_INDEX, 32'h0180); // page 3, inside the section
    boot_core_i.cmd(8'ha3, 2'h1); // reserved bit written too
    see_start(1'b0);
    chk({busy, halt, page}, {2'b10, 9'd3});
    boot_core_i.wr(`ADDR_INDEX, 32'hffff);
    boot_core_i.cmd(8'h91, 2'h1); // ignored while busy, interrupt enable kept
    rdc(`CSR_INDEX, 32'hc3);
    chk(ready_irq, 32'h0);
    wait_idle();
    rdc(`CSR_INDEX, 32'hc0);
    chk({ready_irq, page}, {1'b1, 9'd3});
    gie <= 1'b0;
    repeat (2) @(posedge hclk);
    chk(ready_irq, 32'h0);
    gie <= 1'b1;
    boot_core_i.cmd(8'h11, 2'h1);
    rdc(`CSR_INDEX, 32'h0);
    load_word(16'h000a, 16'h4321);
    chk_buf(6'd5, 16'h4321);
    boot_core_i.wr(`ADDR_INDEX, 32'h0180); // same page as the erase
    boot_core_i.cmd(8'h05, 2'h1);
    see_start(1'b1);
    chk({busy, page}, {1'b1, 9'd3});
    wait_idle();
    load_word(16'h000a, 16'h9999);
    @(posedge hclk);
    chk(busy, 32'h0);
    chk_buf(6'd5, 16'h9999);
    $display("test section finished");
  endtask
  task automatic t_halt();
    boot_core_i.wr(`ADDR_INDEX, 32'h7300); // page 230, outside the section
    boot_core_i.cmd(8'h03, 2'h1);
    see_start(1'b0);
    chk({busy, halt, page}, {2'b01, 9'd230});
    wait_idle();
    chk(halt, 32'h0);
    $display("test halt finished");
  endtask
  task automatic t_lock();
    logic [7:0] exp [4];
    exp = '{8'h5a, 8'hf3, 8'h3c, 8'hc3};
    boot_core_i.wr(`DATA_INDEX, 32'h0000_aaf3); // R1 is noise here
    boot_core_i.cmd(8'h09, 2'h1);
    rdc(`STATUS_INDEX, 32'h00f3_0000);
    chk(lock_bits, 32'hf3);
    rdc(`CSR_INDEX, 32'h0);
    for (int p = 0; p < 4; p++) begin
      boot_core_i.wr(`ADDR_INDEX, 32'(p));
      boot_core_i.cmd(8'h09, 2'h2);
      rdc(`RESULT_INDEX, {24'h0, exp[p]});
    end
    $display("test lock finished");
  endtask
  task automatic t_refuse();
    int s;
    s = starts;
    boot_core_i.cmd(8'h07, 2'h1);
    boot_core_i.wr(`CMD_INDEX, 32'h1);
    rdc(`CSR_INDEX, 32'h0);
    chk(starts, s);
    boot_core_i.wr(`ADDR_INDEX, 32'h000e);
    boot_core_i.wr(`CSR_INDEX, 32'h01);
    repeat (6) @(posedge hclk);
    rdc(`CSR_INDEX, 32'h0);
    boot_core_i.wr(`CMD_INDEX, 32'h1); // late strobe loads nothing
    load_word(16'h000e, 16'h5555);
    chk_buf(6'd7, 16'h5555);
    $display("test refuse finished");
  endtask
  initial begin
    hresetn = 1'b0;
    fuse = 1'b1;
    gie = 1'b1;
    buf_index = '0;
    f_low = 8'h5a;
    f_high = 8'hc3;
    f_ext = 8'h3c;
    @(posedge hclk);
    t_reset();
    t_load();
    t_section();
    t_halt();
    t_lock();
    t_refuse();
    conclude();
  end
endmodule // flash_self_program_control_tb
`default_nettype wire
